/* File: hdl/ipr_ctrl.sv */
// Interrupt priority, masking, nesting and vectoring logic with its register file.
// Summary of operation
// - Each source has a 3-bit level, 7 highest, 1 lowest, 0 turns the source off.
// - After reset every source level field holds 4.
// - Unused bit positions read as zero and ignore writes.
// - A read-only 4-bit field gives the level of the pending request, 0 to 11.
// - A read-only 7-bit field gives the pending vector, 0 to 3 for traps and 8 to 19 for sources.
// - With the nesting-off bit set, a taken user interrupt cannot be pre-empted by another.
// - A handler clears its flag, otherwise the same interrupt is taken again after the return.
// - Return from interrupt restores the previous CPU level from the stack.
// - A trap handler clears its trap flag, otherwise the trap is entered again.
// - The CPU level masks user levels up to 7; traps at 8 to 11 are masked only while a trap at the same or a higher level is in service.
// - The timed disable masks levels 1 to 6 for a count while level 7 still interrupts.
`timescale 1ns/1ps
`default_nettype none
module ipr_ctrl
    import ipr_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_NRST,
    input wire logic [ADDR_W-1:0] I_ADDR,
    input wire logic [DATA_W-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [DATA_W-1:0] O_RDATA,
    input wire logic [SRC_N-1:0] I_SRC_EVT,
    input wire logic [TRAP_N-1:0] I_TRAP_EVT,
    input wire logic I_ACK,
    input wire logic I_RETURN,
    output ipr_req_t O_REQ,
    output logic [3:0] O_CPU_LEVEL,
    output logic O_IRQ
);

////////////////////////////////////////////////////////////////////////////////
logic [1:0] rst_sync_reg;
logic rst_n;

always_ff @(posedge I_CLK or negedge I_NRST)
begin
    if (!I_NRST)
        rst_sync_reg <= 2'h0;
    else
        rst_sync_reg <= {rst_sync_reg[0], 1'b1};
end
assign rst_n = rst_sync_reg[1];

////////////////////////////////////////////////////////////////////////////////
logic [2:0] lvl_reg [SRC_N];
logic [SRC_N-1:0] flag_reg;
logic [SRC_N-1:0] enable_reg;
logic [TRAP_N-1:0] trap_reg;
logic nest_off_reg;
logic [3:0] cpu_level_reg;
logic [TIMED_IRQ_MASK_INSTR_W-1:0] timed_irq_mask_instr_reg;
logic [3:0] stack_mem [STACK_DEPTH];
logic [3:0] sp_reg;
ipr_req_t req_reg;
ipr_req_t req_next;
logic [DATA_W-1:0] rdata_reg;
logic [DATA_W-1:0] rdata_next;
logic [DATA_W-1:0] pri_word [4];
logic [DATA_W-1:0] pvs_word;
logic [3:0] stack_top;
logic take_user;

genvar gi;
generate
    for (gi = 0; gi < SRC_N; gi++)
    begin : g_src
        always_ff @(posedge I_CLK or negedge rst_n)
        begin
            if (!rst_n)
                lvl_reg[gi] <= LVL_RESET;
            else if (I_WR && I_ADDR == SRC_REG[gi])
                lvl_reg[gi] <= I_WDATA[SRC_LSB[gi] +: 3];
        end
    end
endgenerate

// Only the documented field positions are collected, so every other bit stays zero.
always_comb
begin
    for (int r = 0; r < 4; r++)
        pri_word[r] = '0;
    for (int i = 0; i < SRC_N; i++)
        pri_word[SRC_REG[i][1:0]][SRC_LSB[i] +: 3] = lvl_reg[i];
end

////////////////////////////////////////////////////////////////////////////////
// Hardware set wins over a software write-one clear in the same cycle.
always_ff @(posedge I_CLK or negedge rst_n)
begin
    if (!rst_n)
        flag_reg <= '0;
    else if (I_WR && I_ADDR == OFS_FLAG)
        flag_reg <= (flag_reg & ~I_WDATA[SRC_N-1:0]) | I_SRC_EVT;
    else
        flag_reg <= flag_reg | I_SRC_EVT;
end

always_ff @(posedge I_CLK or negedge rst_n)
begin
    if (!rst_n)
        enable_reg <= '0;
    else if (I_WR && I_ADDR == OFS_ENABLE)
        enable_reg <= I_WDATA[SRC_N-1:0];
end

always_ff @(posedge I_CLK or negedge rst_n)
begin
    if (!rst_n)
        trap_reg <= '0;
    else if (I_WR && I_ADDR == OFS_CTRL)
        trap_reg <= (trap_reg & ~I_WDATA[TRAP_N-1:0]) | I_TRAP_EVT;
    else
        trap_reg <= trap_reg | I_TRAP_EVT;
end

always_ff @(posedge I_CLK or negedge rst_n)
begin
    if (!rst_n)
        nest_off_reg <= 1'b0;
    else if (I_WR && I_ADDR == OFS_CTRL)
        nest_off_reg <= I_WDATA[NEST_OFF_BIT];
end

// The count runs down by one each cycle; a write restarts it.
always_ff @(posedge I_CLK or negedge rst_n)
begin
    if (!rst_n)
        timed_irq_mask_instr_reg <= '0;
    else if (I_WR && I_ADDR == OFS_TIMED_IRQ_MASK_INSTR)
        timed_irq_mask_instr_reg <= I_WDATA[TIMED_IRQ_MASK_INSTR_W-1:0];
    else if (timed_irq_mask_instr_reg != '0)
        timed_irq_mask_instr_reg <= timed_irq_mask_instr_reg - 1'b1;
end

////////////////////////////////////////////////////////////////////////////////
// Arbitration: strictly greater level wins, so ties go to the lowest source index.
always_comb
begin
    logic [3:0] u_lvl;
    logic [6:0] u_vec;
    logic [3:0] u_thr;
    logic [3:0] t_lvl;
    logic [6:0] t_vec;
    logic t_any;
    u_lvl = '0;
    u_vec = '0;
    u_thr = '0;
    t_lvl = '0;
    t_vec = '0;
    t_any = 1'b0;
    for (int i = 0; i < SRC_N; i++)
        if (flag_reg[i] && enable_reg[i] && lvl_reg[i] != LVL_OFF
            && {1'b0, lvl_reg[i]} > u_lvl)
        begin
            u_lvl = {1'b0, lvl_reg[i]};
            u_vec = USER_VEC_BASE + 7'(i);
        end
    u_thr = cpu_level_reg;
    if (timed_irq_mask_instr_reg != '0 && cpu_level_reg < LVL_TIMED_IRQ_MASK_INSTR_CEIL)
        u_thr = LVL_TIMED_IRQ_MASK_INSTR_CEIL;
    for (int k = 0; k < TRAP_N; k++)
        if (trap_reg[k])
        begin
            t_any = 1'b1;
            t_lvl = LVL_TRAP_BASE + 4'(k);
            t_vec = 7'(k);
        end
    req_next = '0;
    if (t_any && t_lvl > cpu_level_reg)
    begin
        req_next.valid = 1'b1;
        req_next.level = t_lvl;
        req_next.vec = t_vec;
    end
    else if (u_lvl > u_thr)
    begin
        req_next.valid = 1'b1;
        req_next.level = u_lvl;
        req_next.vec = u_vec;
    end
end

always_ff @(posedge I_CLK or negedge rst_n)
begin
    if (!rst_n)
        req_reg <= '0;
    else
        req_reg <= req_next;
end

////////////////////////////////////////////////////////////////////////////////
// Level stack: an acknowledge pushes, a return pops unless an acknowledge is taken in the same cycle. A full stack drops the push.
assign take_user = I_ACK && req_reg.valid && !req_reg.level[3];
assign stack_top = (sp_reg != 4'h0) ? stack_mem[sp_reg[2:0] - 3'h1] : 4'h0;

always_ff @(posedge I_CLK)
begin
    if (I_ACK && req_reg.valid && sp_reg < 4'(STACK_DEPTH))
        stack_mem[sp_reg[2:0]] <= cpu_level_reg;
end

always_ff @(posedge I_CLK or negedge rst_n)
begin
    if (!rst_n)
        sp_reg <= 4'h0;
    else if (I_ACK && req_reg.valid && sp_reg < 4'(STACK_DEPTH))
        sp_reg <= sp_reg + 4'h1;
    else if (I_RETURN && !(I_ACK && req_reg.valid) && sp_reg != 4'h0)
        sp_reg <= sp_reg - 4'h1;
end

always_ff @(posedge I_CLK or negedge rst_n)
begin
    if (!rst_n)
        cpu_level_reg <= 4'h0;
    else if (I_ACK && req_reg.valid)
        cpu_level_reg <= (take_user && nest_off_reg) ? LVL_USER_TOP : req_reg.level;
    else if (I_RETURN)
        cpu_level_reg <= stack_top;
    else if (I_WR && I_ADDR == OFS_CPU && !cpu_level_reg[3])
        cpu_level_reg <= {1'b0, I_WDATA[2:0]};
end

////////////////////////////////////////////////////////////////////////////////
always_comb
begin
    pvs_word = '0;
    pvs_word[PVS_LVL_LSB +: 4] = req_reg.level;
    pvs_word[PVS_VEC_LSB +: 7] = req_reg.vec;
end

always_comb
begin
    rdata_next = '0;
    if (I_RD)
        unique case (I_ADDR)
            OFS_PRI14: rdata_next = pri_word[0];
            OFS_PRI15: rdata_next = pri_word[1];
            OFS_PRI16: rdata_next = pri_word[2];
            OFS_PRI17: rdata_next = pri_word[3];
            OFS_PVS: rdata_next = pvs_word;
            OFS_FLAG: rdata_next[SRC_N-1:0] = flag_reg;
            OFS_ENABLE: rdata_next[SRC_N-1:0] = enable_reg;
            OFS_CTRL:
            begin
                rdata_next[NEST_OFF_BIT] = nest_off_reg;
                rdata_next[TRAP_N-1:0] = trap_reg;
            end
            OFS_CPU: rdata_next[3:0] = cpu_level_reg;
            OFS_TIMED_IRQ_MASK_INSTR: rdata_next[TIMED_IRQ_MASK_INSTR_W-1:0] = timed_irq_mask_instr_reg;
            default: rdata_next = '0;
        endcase
end

always_ff @(posedge I_CLK or negedge rst_n)
begin
    if (!rst_n)
        rdata_reg <= '0;
    else
        rdata_reg <= rdata_next;
end

assign O_RDATA = rdata_reg;
assign O_REQ = req_reg;
assign O_CPU_LEVEL = cpu_level_reg;
assign O_IRQ = |(flag_reg & enable_reg);

////////////////////////////////////////////////////////////////////////////////
sequence s_top_src_ready;
    flag_reg[0] && enable_reg[0] && lvl_reg[0] == 3'h7
        && cpu_level_reg == 4'h0 && trap_reg == '0;
endsequence

sequence s_pvs_read;
    I_RD && I_ADDR == OFS_PVS;
endsequence

AST_LEVEL_NONZERO: assert property (@(posedge I_CLK) disable iff (!rst_n)
    O_REQ.valid |-> O_REQ.level != 4'h0)
    else $error("presented request has level zero");

AST_RESET_LEVEL: assert property (@(posedge I_CLK)
    $rose(rst_n) |-> lvl_reg[0] == 3'h4 && lvl_reg[11] == 3'h4)
    else $error("level field not four after reset");

AST_UNUSED_ZERO: assert property (@(posedge I_CLK) disable iff (!rst_n)
    I_RD && I_ADDR == OFS_PRI14 |=> O_RDATA[15:11] == 5'h00 && !O_RDATA[7] && !O_RDATA[3])
    else $error("unused bit reads as one");

AST_STATUS_READ: assert property (@(posedge I_CLK) disable iff (!rst_n)
    s_pvs_read |=> O_RDATA == $past(pvs_word) && O_RDATA[11:8] == $past(req_reg.level))
    else $error("status word does not match request");

AST_NEST_OFF: assert property (@(posedge I_CLK) disable iff (!rst_n)
    take_user && nest_off_reg |=> cpu_level_reg == 4'h7)
    else $error("nesting not blocked after acknowledge");

AST_RETURN_LEVEL: assert property (@(posedge I_CLK) disable iff (!rst_n)
    I_RETURN && !I_ACK && sp_reg != 4'h0 |=> cpu_level_reg == $past(stack_top)
        && sp_reg == $past(sp_reg) - 4'h1)
    else $error("return did not restore level");

AST_TRAP_UNMASKED: assert property (@(posedge I_CLK) disable iff (!rst_n)
    trap_reg != '0 && !cpu_level_reg[3] |=> O_REQ.valid && O_REQ.level[3])
    else $error("trap masked by cpu level");

AST_TIMED_IRQ_MASK_INSTR_MASK: assert property (@(posedge I_CLK) disable iff (!rst_n)
    timed_irq_mask_instr_reg != '0 && trap_reg == '0 |=> !(O_REQ.valid && O_REQ.level < 4'h7))
    else $error("level below seven passed timed disable");

AST_HIGHEST_WINS: assert property (@(posedge I_CLK) disable iff (!rst_n)
    s_top_src_ready |=> O_REQ.valid && O_REQ.vec == USER_VEC_BASE && O_REQ.level == 4'h7)
    else $error("highest source not presented");

endmodule
`default_nettype wire

/* File: hdl/ipr_pkg.sv */
// Shared constants, register map and carrier types of the interrupt priority controller.
package ipr_pkg;
    localparam int SRC_N = 12;
    localparam int TRAP_N = 4;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int STACK_DEPTH = 8;
    localparam int TIMED_IRQ_MASK_INSTR_W = 14;

    localparam logic [3:0] OFS_PRI14 = 4'h0;
    localparam logic [3:0] OFS_PRI15 = 4'h1;
    localparam logic [3:0] OFS_PRI16 = 4'h2;
    localparam logic [3:0] OFS_PRI17 = 4'h3;
    localparam logic [3:0] OFS_PVS = 4'h4;
    localparam logic [3:0] OFS_FLAG = 4'h5;
    localparam logic [3:0] OFS_ENABLE = 4'h6;
    localparam logic [3:0] OFS_CTRL = 4'h7;
    localparam logic [3:0] OFS_CPU = 4'h8;
    localparam logic [3:0] OFS_TIMED_IRQ_MASK_INSTR = 4'h9;

    // Register index and field position of each source's level field.
    localparam logic [3:0] SRC_REG [SRC_N] = '{
        4'h0, 4'h0, 4'h0, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h3, 4'h3, 4'h3, 4'h3};
    localparam int SRC_LSB [SRC_N] = '{8, 4, 0, 12, 4, 8, 4, 0, 12, 8, 4, 0};

    localparam logic [2:0] LVL_RESET = 3'h4;
    localparam logic [2:0] LVL_OFF = 3'h0;
    localparam int NEST_OFF_BIT = 15;
    localparam int PVS_LVL_LSB = 8;
    localparam int PVS_VEC_LSB = 0;
    localparam logic [3:0] LVL_USER_TOP = 4'h7;
    localparam logic [3:0] LVL_TIMED_IRQ_MASK_INSTR_CEIL = 4'h6;
    localparam logic [3:0] LVL_TRAP_BASE = 4'h8;
    localparam logic [6:0] USER_VEC_BASE = 7'h08;

    typedef struct packed {
        logic valid;
        logic [3:0] level;
        logic [6:0] vec;
    } ipr_req_t;
endpackage

/* File: bench/ipr_core_model.sv */
// Core side model that takes a presented request while told to.
`timescale 1ns/1ps
`default_nettype none
module ipr_core_model
    import ipr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_go,
    input wire ipr_req_t i_req,
    output logic o_ack
);
    logic ack_d_reg;
    // The presented request lags one cycle, so a second take waits two cycles.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_ack <= 1'b0;
            ack_d_reg <= 1'b0;
        end
        else
        begin
            o_ack <= i_go && i_req.valid && !o_ack && !ack_d_reg;
            ack_d_reg <= o_ack;
        end
    end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the interrupt priority controller.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import ipr_pkg::*;
;
    localparam logic [15:0] MSK [4] = '{16'h0777, 16'h7070, 16'h0777, 16'h7777};
    logic clk, nrst, wr, rd, ack, ret, go, irq;
    logic [3:0] addr, trap, cpu_level;
    logic [15:0] wdata, rdata;
    logic [11:0] src;
    ipr_req_t req;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    ipr_ctrl u_ipr_ctrl (.I_CLK(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_SRC_EVT(src), .I_TRAP_EVT(trap),
        .I_ACK(ack), .I_RETURN(ret), .O_REQ(req), .O_CPU_LEVEL(cpu_level), .O_IRQ(irq));
    ipr_core_model u_ipr_core_model (.i_clk(clk), .i_nrst(nrst), .i_go(go), .i_req(req),
        .o_ack(ack));
    always #12.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // A hung handshake would otherwise stall the run forever.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            bad_count++;
            test_done();
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] pv(input logic [3:0] l, input logic [6:0] v);
        return {4'h0, l, 1'b0, v};
    endfunction
    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        // Let the written register settle so that a check right after the call sees it.
        #1;
    endtask
    task automatic bus_rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask
    task automatic pulse(input logic [11:0] s, input logic [3:0] t);
        @(posedge clk);
        src <= s;
        trap <= t;
        @(posedge clk);
        src <= 12'h000;
        trap <= 4'h0;
        repeat (3) @(posedge clk);
    endtask
    task automatic take();
        @(posedge clk);
        go <= 1'b1;
        repeat (8)
        begin
            @(posedge clk);
            if (ack === 1'b1)
                break;
        end
        go <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic leave();
        @(posedge clk);
        ret <= 1'b1;
        @(posedge clk);
        ret <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {clk, nrst, wr, rd, ret, go, addr, trap, wdata, src} = '0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 4; i++)
        begin
            bus_rd(i[3:0], MSK[i] & 16'h4444);
            bus_wr(i[3:0], 16'hffff);
            bus_rd(i[3:0], MSK[i]);
        end
        bus_wr(4'ha, 16'hffff);
        bus_rd(4'ha, 16'h0000);
        $display("register map test done");
        bus_wr(OFS_PRI14, 16'h0102);
        bus_wr(OFS_PRI15, 16'h5000);
        bus_wr(OFS_PRI16, 16'h0000);
        bus_wr(OFS_PRI17, 16'h7600);
        bus_wr(OFS_FLAG, 16'h0fff);
        bus_wr(OFS_ENABLE, 16'h0fff);
        pulse(12'h00b, 4'h0);
        bus_rd(OFS_PVS, pv(4'h5, 7'h0b));
        check({15'h0, irq}, 16'h0001);
        bus_wr(OFS_ENABLE, 16'h0002);
        repeat (3) @(posedge clk);
        check({15'h0, req.valid}, 16'h0000);
        bus_wr(OFS_ENABLE, 16'h0000);
        check({15'h0, irq}, 16'h0000);
        bus_wr(OFS_ENABLE, 16'h0fff);
        bus_wr(OFS_CPU, 16'h0007);
        repeat (3) @(posedge clk);
        check({15'h0, req.valid}, 16'h0000);
        pulse(12'h000, 4'h4);
        bus_rd(OFS_PVS, pv(4'ha, 7'h02));
        bus_wr(OFS_CTRL, 16'h0004);
        repeat (3) @(posedge clk);
        check({15'h0, req.valid}, 16'h0000);
        bus_wr(OFS_CPU, 16'h0000);
        $display("masking test done");
        take();
        check({12'h0, cpu_level}, 16'h0005);
        check({15'h0, req.valid}, 16'h0000);
        bus_wr(OFS_FLAG, 16'h0008);
        leave();
        check({12'h0, cpu_level}, 16'h0000);
        bus_rd(OFS_PVS, pv(4'h1, 7'h08));
        take();
        leave();
        bus_rd(OFS_PVS, pv(4'h1, 7'h08));
        bus_wr(OFS_CTRL, 16'h8000);
        take();
        check({12'h0, cpu_level}, 16'h0007);
        leave();
        bus_wr(OFS_CTRL, 16'h0000);
        bus_wr(OFS_FLAG, 16'h0fff);
        check({15'h0, irq}, 16'h0000);
        $display("nesting test done");
        bus_wr(OFS_TIMED_IRQ_MASK_INSTR, 16'h0028);
        pulse(12'h200, 4'h0);
        check({15'h0, req.valid}, 16'h0000);
        pulse(12'h100, 4'h0);
        bus_rd(OFS_PVS, pv(4'h7, 7'h10));
        repeat (40) @(posedge clk);
        bus_wr(OFS_FLAG, 16'h0100);
        repeat (3) @(posedge clk);
        bus_rd(OFS_PVS, pv(4'h6, 7'h11));
        $display("timed disable test done");
        for (int i = 0; i < 4; i++)
            bus_wr(i[3:0], MSK[i]);
        pulse(12'h001, 4'h0);
        bus_rd(OFS_PVS, pv(4'h7, 7'h08));
        $display("common level test done");
        test_done();
    end
endmodule
`default_nettype wire
